// ==== design/afr_route_cfg.sv ====
// Alternate-function routing register with its pin multiplexing decode.
// Assumes a classic Wishbone master on i_clk and an active-low async reset.
//
// Design decision made here: the Wishbone slave port.
`timescale 1ns/1ps
`include "afr_map.svh"

module afr_route_cfg
   import afr_pkg::*;
(
   input  wire logic        i_clk,
   input  wire logic        i_nrst,
   input  wire logic        i_wb_cyc,
   input  wire logic        i_wb_stb,
   input  wire logic        i_wb_we,
   input  wire logic [7:0]  i_wb_adr,
   input  wire logic [3:0]  i_wb_sel,
   input  wire logic [31:0] i_wb_dat,
   output logic             o_wb_ack,
   output logic [31:0]      o_wb_dat,
   output afr_route_t       o_route
);

   // ----------------------------------------------------------------------
   // Storage and decode helpers
   // ----------------------------------------------------------------------
   logic [31:0] cfg3;
   logic [31:0] low;
   logic        req;
   logic        hit_cfg3;
   logic        hit_low;
   logic [31:0] lane_mask;
   logic [31:0] next_rdat;
   afr_route_t  next_route;
   logic [1:0]  sync2_code;
   logic [1:0]  spi1_code;

   function automatic afr_loc_t loc(input logic [2:0] p, input logic [3:0] n);
      afr_loc_t r;
      r.valid = 1'b1;
      r.port  = p;
      r.pin   = n;
      return r;
   endfunction

   function automatic afr_pair_t pair(input afr_loc_t a, input afr_loc_t b);
      afr_pair_t r;
      r.a = a;
      r.b = b;
      return r;
   endfunction

   function automatic afr_spi_t spi(input afr_loc_t s, input afr_loc_t c, input afr_loc_t mi,
                                    input afr_loc_t mo);
      afr_spi_t r;
      r.sel  = s;
      r.clk  = c;
      r.miso = mi;
      r.mosi = mo;
      return r;
   endfunction

   // ----------------------------------------------------------------------
   // Wishbone slave
   // ----------------------------------------------------------------------
   assign req      = i_wb_cyc & i_wb_stb;
   assign hit_cfg3 = (i_wb_adr[7:2] == 6'(`AFR_CFG3_OFS >> 2));
   assign hit_low  = (i_wb_adr[7:2] == 6'(`AFR_LOW_OFS >> 2));

   genvar gb;
   generate
      for (gb = 0; gb < 4; gb = gb + 1)
      begin : g_lane
         assign lane_mask[gb*8 +: 8] = {8{i_wb_sel[gb]}};
      end
   endgenerate

   always_comb
   begin
      next_rdat = 32'h00000000;
      if (hit_cfg3)
      begin
         next_rdat = cfg3;
      end
      else if (hit_low)
      begin
         next_rdat = low;
      end
   end

   // Each request is answered one cycle after it is taken; ack then drops.
   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         o_wb_ack <= 1'b0;
      end
      else
      begin
         o_wb_ack <= req & ~o_wb_ack;
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         o_wb_dat <= 32'h00000000;
      end
      else if (req & ~o_wb_ack)
      begin
         o_wb_dat <= next_rdat;
      end
   end

   // Writes land on the edge where the master samples ack; reserved bits stay zero.
   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         cfg3 <= `AFR_CFG3_RST;
      end
      else if (req & i_wb_we & o_wb_ack & hit_cfg3)
      begin
         cfg3 <= (cfg3 & ~(lane_mask & `AFR_CFG3_WMASK)) |
                 (i_wb_dat & lane_mask & `AFR_CFG3_WMASK);
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         low <= `AFR_LOW_RST;
      end
      else if (req & i_wb_we & o_wb_ack & hit_low)
      begin
         low <= (low & ~(lane_mask & `AFR_LOW_WMASK)) | (i_wb_dat & lane_mask & `AFR_LOW_WMASK);
      end
   end

   // ----------------------------------------------------------------------
   // Route decode
   // ----------------------------------------------------------------------
   assign sync2_code = {cfg3[`AFR_SYNC2_HI], low[`AFR_SYNC2_LO]};
   assign spi1_code  = {cfg3[`AFR_SPI1_HI], low[`AFR_SPI1_LO]};

   always_comb
   begin
      next_route = '0;

      case (cfg3[`AFR_TIM8_LSB +: 2])
         2'h0:
         begin
            next_route.timer8.timer_external_trigger  = loc(`AFR_PORT_A, 4'h0);
            next_route.timer8.ch1                     = loc(`AFR_PORT_C, 4'h6);
            next_route.timer8.ch2                     = loc(`AFR_PORT_C, 4'h7);
            next_route.timer8.ch3                     = loc(`AFR_PORT_C, 4'h8);
            next_route.timer8.ch4                     = loc(`AFR_PORT_C, 4'h9);
            next_route.timer8.timer_break_input       = loc(`AFR_PORT_A, 4'h6);
            next_route.timer8.timer_comp_output_one   = loc(`AFR_PORT_A, 4'h7);
            next_route.timer8.timer_comp_output_two   = loc(`AFR_PORT_B, 4'h0);
            next_route.timer8.timer_comp_output_three = loc(`AFR_PORT_B, 4'h1);
         end
         2'h1, 2'h3:
         begin
            next_route.timer8.timer_external_trigger  = loc(`AFR_PORT_B, 4'h4);
            next_route.timer8.ch1                     = loc(`AFR_PORT_C, 4'h6);
            next_route.timer8.ch2                     = loc(`AFR_PORT_C, 4'h7);
            next_route.timer8.ch3                     = loc(`AFR_PORT_C, 4'h8);
            next_route.timer8.ch4                     = loc(`AFR_PORT_C, 4'h9);
            next_route.timer8.timer_break_input       = loc(`AFR_PORT_B, 4'h3);
            next_route.timer8.timer_comp_output_one   = loc(`AFR_PORT_A, 4'hf);
            next_route.timer8.timer_comp_output_two   = loc(`AFR_PORT_C, 4'hc);
            next_route.timer8.timer_comp_output_three = loc(`AFR_PORT_D, 4'h2);
            if (cfg3[`AFR_TIM8_LSB + 1])
            begin
               next_route.timer8.ch1 = loc(`AFR_PORT_D, 4'he);
               next_route.timer8.ch2 = loc(`AFR_PORT_D, 4'hf);
            end
         end
         default:
         begin
            next_route.timer8 = '0;
         end
      endcase

      case (cfg3[`AFR_SER7_LSB +: 2])
         2'h0:    next_route.ser7 = pair(loc(`AFR_PORT_C, 4'h4), loc(`AFR_PORT_C, 4'h5));
         2'h1:    next_route.ser7 = pair(loc(`AFR_PORT_C, 4'h2), loc(`AFR_PORT_C, 4'h3));
         default: next_route.ser7 = '0;
      endcase

      case (cfg3[`AFR_SER6_LSB +: 2])
         2'h0:    next_route.ser6 = pair(loc(`AFR_PORT_E, 4'h2), loc(`AFR_PORT_E, 4'h3));
         2'h2:    next_route.ser6 = pair(loc(`AFR_PORT_C, 4'h0), loc(`AFR_PORT_C, 4'h1));
         2'h3:    next_route.ser6 = pair(loc(`AFR_PORT_B, 4'h0), loc(`AFR_PORT_B, 4'h1));
         default: next_route.ser6 = '0;
      endcase

      case (cfg3[`AFR_SER5_LSB +: 2])
         2'h0:    next_route.ser5 = pair(loc(`AFR_PORT_C, 4'hc), loc(`AFR_PORT_D, 4'h2));
         2'h1:    next_route.ser5 = pair(loc(`AFR_PORT_B, 4'hd), loc(`AFR_PORT_B, 4'he));
         2'h2:    next_route.ser5 = pair(loc(`AFR_PORT_E, 4'h8), loc(`AFR_PORT_E, 4'h9));
         default: next_route.ser5 = pair(loc(`AFR_PORT_B, 4'h8), loc(`AFR_PORT_B, 4'h9));
      endcase

      case (cfg3[`AFR_SER4_LSB +: 2])
         2'h0:    next_route.ser4 = pair(loc(`AFR_PORT_C, 4'ha), loc(`AFR_PORT_C, 4'hb));
         2'h1:    next_route.ser4 = pair(loc(`AFR_PORT_B, 4'h2), loc(`AFR_PORT_E, 4'h7));
         2'h2:    next_route.ser4 = pair(loc(`AFR_PORT_A, 4'hd), loc(`AFR_PORT_A, 4'he));
         default: next_route.ser4 = pair(loc(`AFR_PORT_D, 4'h0), loc(`AFR_PORT_D, 4'h1));
      endcase

      case (sync2_code)
         2'h0:
         begin
            next_route.sync2.cts = loc(`AFR_PORT_A, 4'h0);
            next_route.sync2.rts = loc(`AFR_PORT_A, 4'h1);
            next_route.sync2.tx  = loc(`AFR_PORT_A, 4'h2);
            next_route.sync2.rx  = loc(`AFR_PORT_A, 4'h3);
            next_route.sync2.clk = loc(`AFR_PORT_A, 4'h4);
         end
         2'h2:
         begin
            next_route.sync2.cts = loc(`AFR_PORT_C, 4'h6);
            next_route.sync2.rts = loc(`AFR_PORT_C, 4'h7);
            next_route.sync2.tx  = loc(`AFR_PORT_C, 4'h8);
            next_route.sync2.rx  = loc(`AFR_PORT_C, 4'h9);
            next_route.sync2.clk = '0;
         end
         2'h3:
         begin
            next_route.sync2.cts = loc(`AFR_PORT_A, 4'hf);
            next_route.sync2.rts = loc(`AFR_PORT_B, 4'h3);
            next_route.sync2.tx  = loc(`AFR_PORT_B, 4'h4);
            next_route.sync2.rx  = loc(`AFR_PORT_B, 4'h5);
            next_route.sync2.clk = loc(`AFR_PORT_A, 4'h4);
         end
         default:
         begin
            next_route.sync2 = '0;
         end
      endcase

      case (spi1_code)
         2'h0:    next_route.spi1 = spi(loc(`AFR_PORT_A, 4'h4), loc(`AFR_PORT_A, 4'h5),
                                        loc(`AFR_PORT_A, 4'h6), loc(`AFR_PORT_A, 4'h7));
         2'h1:    next_route.spi1 = spi(loc(`AFR_PORT_A, 4'hf), loc(`AFR_PORT_B, 4'h3),
                                        loc(`AFR_PORT_B, 4'h4), loc(`AFR_PORT_B, 4'h5));
         2'h2:    next_route.spi1 = spi(loc(`AFR_PORT_B, 4'h2), loc(`AFR_PORT_A, 4'h5),
                                        loc(`AFR_PORT_A, 4'h6), loc(`AFR_PORT_A, 4'h7));
         default: next_route.spi1 = spi(loc(`AFR_PORT_B, 4'h2), loc(`AFR_PORT_E, 4'h7),
                                        loc(`AFR_PORT_E, 4'h8), loc(`AFR_PORT_E, 4'h9));
      endcase

      case (cfg3[`AFR_SPI3_LSB +: 2])
         2'h0:    next_route.spi3 = spi(loc(`AFR_PORT_A, 4'hf), loc(`AFR_PORT_B, 4'h3),
                                        loc(`AFR_PORT_B, 4'h4), loc(`AFR_PORT_B, 4'h5));
         2'h1:    next_route.spi3 = spi(loc(`AFR_PORT_D, 4'h2), loc(`AFR_PORT_C, 4'ha),
                                        loc(`AFR_PORT_C, 4'hb), loc(`AFR_PORT_C, 4'hc));
         2'h3:    next_route.spi3 = spi(loc(`AFR_PORT_C, 4'h2), loc(`AFR_PORT_C, 4'h3),
                                        loc(`AFR_PORT_A, 4'h0), loc(`AFR_PORT_A, 4'h1));
         default: next_route.spi3 = '0;
      endcase

      case (cfg3[`AFR_SPI2_LSB +: 2])
         2'h0:    next_route.spi2 = spi(loc(`AFR_PORT_B, 4'hc), loc(`AFR_PORT_B, 4'hd),
                                        loc(`AFR_PORT_B, 4'he), loc(`AFR_PORT_B, 4'hf));
         2'h1:    next_route.spi2 = spi(loc(`AFR_PORT_C, 4'h6), loc(`AFR_PORT_C, 4'h7),
                                        loc(`AFR_PORT_C, 4'h8), loc(`AFR_PORT_C, 4'h9));
         2'h3:    next_route.spi2 = spi(loc(`AFR_PORT_E, 4'ha), loc(`AFR_PORT_E, 4'hb),
                                        loc(`AFR_PORT_E, 4'hc), loc(`AFR_PORT_E, 4'hd));
         default: next_route.spi2 = '0;
      endcase

      case (cfg3[`AFR_I2C4_LSB +: 2])
         2'h0:    next_route.i2c4 = pair(loc(`AFR_PORT_C, 4'h6), loc(`AFR_PORT_C, 4'h7));
         2'h1:    next_route.i2c4 = pair(loc(`AFR_PORT_D, 4'he), loc(`AFR_PORT_D, 4'hf));
         2'h3:    next_route.i2c4 = pair(loc(`AFR_PORT_A, 4'h9), loc(`AFR_PORT_A, 4'ha));
         default: next_route.i2c4 = '0;
      endcase

      case (cfg3[`AFR_I2C3_LSB +: 2])
         2'h0:    next_route.i2c3 = pair(loc(`AFR_PORT_C, 4'h0), loc(`AFR_PORT_C, 4'h1));
         2'h3:    next_route.i2c3 = pair(loc(`AFR_PORT_C, 4'h4), loc(`AFR_PORT_C, 4'h5));
         default: next_route.i2c3 = '0;
      endcase
   end

   // The route table is registered so that it comes straight from flip-flops.
   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         o_route <= '0;
      end
      else
      begin
         o_route <= next_route;
      end
   end

   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_nrst);

   a_ack_after_req: assert property (req && !o_wb_ack |=> o_wb_ack ##1 !o_wb_ack)
      else $error("Wishbone ack did not pulse for one cycle after a request.");

   a_ack_needs_req: assert property (o_wb_ack |-> $past(req))
      else $error("Wishbone ack without a preceding request.");

   a_timer_default: assert property (cfg3[31:30] == 2'h0 |=>
         o_route.timer8.timer_external_trigger == loc(`AFR_PORT_A, 4'h0) &&
         o_route.timer8.timer_comp_output_two == loc(`AFR_PORT_B, 4'h0))
      else $error("Timer default route wrong.");

   a_timer_part: assert property (cfg3[31:30] == 2'h1 |=>
         o_route.timer8.timer_break_input == loc(`AFR_PORT_B, 4'h3) &&
         o_route.timer8.ch1 == loc(`AFR_PORT_C, 4'h6))
      else $error("Timer code 01 route wrong.");

   a_timer_full: assert property (cfg3[31:30] == 2'h3 |=>
         o_route.timer8.ch1 == loc(`AFR_PORT_D, 4'he) &&
         o_route.timer8.ch2 == loc(`AFR_PORT_D, 4'hf) &&
         o_route.timer8.timer_comp_output_three == loc(`AFR_PORT_D, 4'h2))
      else $error("Timer code 11 route wrong.");

   a_sync_no_clk: assert property ({cfg3[19], low[0]} == 2'h2 |=>
         !o_route.sync2.clk.valid && o_route.sync2.cts == loc(`AFR_PORT_C, 4'h6))
      else $error("Sync serial two code 10 route wrong.");

   a_spi_one_split: assert property ({cfg3[18], low[1]} == 2'h3 |=>
         o_route.spi1.sel == loc(`AFR_PORT_B, 4'h2) &&
         o_route.spi1.clk == loc(`AFR_PORT_E, 4'h7))
      else $error("SPI one code 11 route wrong.");

   a_unused_none: assert property (1'b1 |=>
         o_route.ser7.a.valid == !$past(cfg3[27]) &&
         o_route.i2c3.b.valid == ($past(cfg3[9]) == $past(cfg3[8])))
      else $error("Unused code still routes a pin.");

   a_reserved_zero: assert property (o_wb_ack && $past(hit_cfg3) |->
         o_wb_dat[29:28] == 2'h0 && o_wb_dat[17:16] == 2'h0 && o_wb_dat[7:0] == 8'h00)
      else $error("Reserved bits read as nonzero.");

   a_write_stored: assert property (req && i_wb_we && o_wb_ack && hit_cfg3 && i_wb_sel == 4'hf |=>
         cfg3 == ($past(i_wb_dat) & `AFR_CFG3_WMASK))
      else $error("Full write to the routing register not stored.");

endmodule

// ==== design/afr_map.svh ====
// Register map constants for the alternate-function routing block.
// Assumes a 32-bit classic Wishbone slave port with byte addresses.
`ifndef AFR_MAP_SVH
`define AFR_MAP_SVH

// ----------------------------------------------------------------------
// Register offsets, reset values and write masks
// ----------------------------------------------------------------------
`define AFR_CFG3_OFS    8'h20
`define AFR_LOW_OFS     8'h40
`define AFR_CFG3_RST    32'h00000000
`define AFR_LOW_RST     32'h00000000
`define AFR_CFG3_WMASK  32'hcffcff00
`define AFR_LOW_WMASK   32'h00000003

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define AFR_TIM8_LSB    30
`define AFR_SER7_LSB    26
`define AFR_SER6_LSB    24
`define AFR_SER5_LSB    22
`define AFR_SER4_LSB    20
`define AFR_SYNC2_HI    19
`define AFR_SPI1_HI     18
`define AFR_SPI3_LSB    14
`define AFR_SPI2_LSB    12
`define AFR_I2C4_LSB    10
`define AFR_I2C3_LSB    8
`define AFR_SYNC2_LO    0
`define AFR_SPI1_LO     1

// ----------------------------------------------------------------------
// Port letter codes
// ----------------------------------------------------------------------
`define AFR_PORT_A      3'h0
`define AFR_PORT_B      3'h1
`define AFR_PORT_C      3'h2
`define AFR_PORT_D      3'h3
`define AFR_PORT_E      3'h4

`endif

// ==== design/afr_pkg.sv ====
// Types shared by the alternate-function routing block.
// Assumes the pin locator carries a port letter code and a pin number.
package afr_pkg;

   // ----------------------------------------------------------------------
   // Pin locator and per-peripheral signal groups
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic       valid;
      logic [2:0] port;
      logic [3:0] pin;
   } afr_loc_t;

   typedef struct packed {
      afr_loc_t timer_external_trigger;
      afr_loc_t ch1;
      afr_loc_t ch2;
      afr_loc_t ch3;
      afr_loc_t ch4;
      afr_loc_t timer_break_input;
      afr_loc_t timer_comp_output_one;
      afr_loc_t timer_comp_output_two;
      afr_loc_t timer_comp_output_three;
   } afr_timer_t;

   typedef struct packed {
      afr_loc_t a;
      afr_loc_t b;
   } afr_pair_t;

   typedef struct packed {
      afr_loc_t cts;
      afr_loc_t rts;
      afr_loc_t tx;
      afr_loc_t rx;
      afr_loc_t clk;
   } afr_sync_t;

   typedef struct packed {
      afr_loc_t sel;
      afr_loc_t clk;
      afr_loc_t miso;
      afr_loc_t mosi;
   } afr_spi_t;

   typedef struct packed {
      afr_timer_t timer8;
      afr_pair_t  ser7;
      afr_pair_t  ser6;
      afr_pair_t  ser5;
      afr_pair_t  ser4;
      afr_sync_t  sync2;
      afr_spi_t   spi1;
      afr_spi_t   spi3;
      afr_spi_t   spi2;
      afr_pair_t  i2c4;
      afr_pair_t  i2c3;
   } afr_route_t;

endpackage

// ==== verif/test_afr_route_cfg.sv ====
// Self-checking bench for the alternate-function routing register.
// Assumes afr_pkg is compiled first and afr_map.svh is on the include path.
`timescale 1ns/1ps
`include "afr_map.svh"

module test_afr_route_cfg
   import afr_pkg::*;
   ;

   // --------------------------------------------------------------------
   // Signals and bookkeeping
   // --------------------------------------------------------------------
   localparam logic [2:0] pa = `AFR_PORT_A;
   localparam logic [2:0] pb = `AFR_PORT_B;
   localparam logic [2:0] pc = `AFR_PORT_C;
   localparam logic [2:0] pd = `AFR_PORT_D;
   localparam logic [2:0] pe = `AFR_PORT_E;
   localparam int         rw = $bits(afr_route_t);

   logic        i_clk;
   logic        i_nrst;
   logic        i_wb_cyc;
   logic        i_wb_stb;
   logic        i_wb_we;
   logic [7:0]  i_wb_adr;
   logic [3:0]  i_wb_sel;
   logic [31:0] i_wb_dat;
   logic        o_wb_ack;
   logic [31:0] o_wb_dat;
   afr_route_t  o_route;
   logic [31:0] exp_q[$];
   logic [31:0] cfg_m;
   logic [1:0]  low_m;
   logic [1:0]  c;
   integer      seed;
   int          n_fail;
   int          comparisons;
   int          cycles;

   afr_route_cfg dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
                      .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel),
                      .i_wb_dat(i_wb_dat), .o_wb_ack(o_wb_ack), .o_wb_dat(o_wb_dat),
                      .o_route(o_route));

   // --------------------------------------------------------------------
   // Expected routing
   // --------------------------------------------------------------------
   function automatic afr_loc_t l(input logic [2:0] p, input int n);
      return {1'b1, p, n[3:0]};
   endfunction

   function automatic afr_route_t ex(input logic [31:0] g, input logic [1:0] lo);
      afr_route_t r;
      r = '0;
      case (g[31:30])
         2'h0: r.timer8 = '{l(pa,0), l(pc,6), l(pc,7), l(pc,8), l(pc,9), l(pa,6), l(pa,7), l(pb,0), l(pb,1)};
         2'h1: r.timer8 = '{l(pb,4), l(pc,6), l(pc,7), l(pc,8), l(pc,9), l(pb,3), l(pa,15), l(pc,12), l(pd,2)};
         2'h3: r.timer8 = '{l(pb,4), l(pd,14), l(pd,15), l(pc,8), l(pc,9), l(pb,3), l(pa,15), l(pc,12), l(pd,2)};
         default: ;
      endcase
      case (g[27:26])
         2'h0: r.ser7 = '{l(pc,4), l(pc,5)};
         2'h1: r.ser7 = '{l(pc,2), l(pc,3)};
         default: ;
      endcase
      case (g[25:24])
         2'h0: r.ser6 = '{l(pe,2), l(pe,3)};
         2'h2: r.ser6 = '{l(pc,0), l(pc,1)};
         2'h3: r.ser6 = '{l(pb,0), l(pb,1)};
         default: ;
      endcase
      case (g[23:22])
         2'h0: r.ser5 = '{l(pc,12), l(pd,2)};
         2'h1: r.ser5 = '{l(pb,13), l(pb,14)};
         2'h2: r.ser5 = '{l(pe,8), l(pe,9)};
         default: r.ser5 = '{l(pb,8), l(pb,9)};
      endcase
      case (g[21:20])
         2'h0: r.ser4 = '{l(pc,10), l(pc,11)};
         2'h1: r.ser4 = '{l(pb,2), l(pe,7)};
         2'h2: r.ser4 = '{l(pa,13), l(pa,14)};
         default: r.ser4 = '{l(pd,0), l(pd,1)};
      endcase
      case ({g[19], lo[0]})
         2'h0: r.sync2 = '{l(pa,0), l(pa,1), l(pa,2), l(pa,3), l(pa,4)};
         2'h2: r.sync2 = '{l(pc,6), l(pc,7), l(pc,8), l(pc,9), '0};
         2'h3: r.sync2 = '{l(pa,15), l(pb,3), l(pb,4), l(pb,5), l(pa,4)};
         default: ;
      endcase
      case ({g[18], lo[1]})
         2'h0: r.spi1 = '{l(pa,4), l(pa,5), l(pa,6), l(pa,7)};
         2'h1: r.spi1 = '{l(pa,15), l(pb,3), l(pb,4), l(pb,5)};
         2'h2: r.spi1 = '{l(pb,2), l(pa,5), l(pa,6), l(pa,7)};
         default: r.spi1 = '{l(pb,2), l(pe,7), l(pe,8), l(pe,9)};
      endcase
      case (g[15:14])
         2'h0: r.spi3 = '{l(pa,15), l(pb,3), l(pb,4), l(pb,5)};
         2'h1: r.spi3 = '{l(pd,2), l(pc,10), l(pc,11), l(pc,12)};
         2'h3: r.spi3 = '{l(pc,2), l(pc,3), l(pa,0), l(pa,1)};
         default: ;
      endcase
      case (g[13:12])
         2'h0: r.spi2 = '{l(pb,12), l(pb,13), l(pb,14), l(pb,15)};
         2'h1: r.spi2 = '{l(pc,6), l(pc,7), l(pc,8), l(pc,9)};
         2'h3: r.spi2 = '{l(pe,10), l(pe,11), l(pe,12), l(pe,13)};
         default: ;
      endcase
      case (g[11:10])
         2'h0: r.i2c4 = '{l(pc,6), l(pc,7)};
         2'h1: r.i2c4 = '{l(pd,14), l(pd,15)};
         2'h3: r.i2c4 = '{l(pa,9), l(pa,10)};
         default: ;
      endcase
      if (g[9:8] == 2'h0)
         r.i2c3 = '{l(pc,0), l(pc,1)};
      else if (g[9:8] == 2'h3)
         r.i2c3 = '{l(pc,4), l(pc,5)};
      return r;
   endfunction

   // Entries routed nowhere are compared on their valid bit only.
   function automatic afr_route_t nz(input afr_route_t r);
      for (int i = 0; i < rw / 8; i++)
         if (r[i*8+7] !== 1'b1)
            r[i*8+:8] = 8'h00;
      return r;
   endfunction

   // --------------------------------------------------------------------
   // Tasks
   // --------------------------------------------------------------------
   task cmp(input logic [rw-1:0] e, input logic [rw-1:0] g);
      comparisons++;
      if (g !== e)
      begin
         n_fail++;
         $display("[FAIL] %0t exp %h got %h", $time, e, g);
      end
   endtask

   task finish_test();
      $display("Mismatches %0d, comparisons %0d.", n_fail, comparisons);
      if (n_fail == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task wb(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
      @(posedge i_clk);
      i_wb_cyc <= 1'b1;
      i_wb_stb <= 1'b1;
      i_wb_we  <= w;
      i_wb_adr <= a;
      i_wb_sel <= s;
      i_wb_dat <= d;
      do
      begin
         @(posedge i_clk);
      end
      while (o_wb_ack !== 1'b1);
      i_wb_cyc <= 1'b0;
      i_wb_stb <= 1'b0;
   endtask

   task wr(input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
      logic [31:0] bm;
      bm = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
      if (a[7:2] == 6'h08)
         cfg_m = ((cfg_m & ~bm) | (d & bm)) & `AFR_CFG3_WMASK;
      else if (a[7:2] == 6'h10 && s[0])
         low_m = d[1:0];
      wb(1'b1, a, s, d);
   endtask

   task rd(input logic [7:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      wb(1'b0, a, 4'hf, 32'h0);
   endtask

   task chk_route();
      repeat (2) @(posedge i_clk);
      @(negedge i_clk);
      cmp(nz(ex(cfg_m, low_m)), nz(o_route));
   endtask

   // --------------------------------------------------------------------
   // Clock, monitor and timeout
   // --------------------------------------------------------------------
   initial
   begin
      i_clk = 1'b0;
      forever #4 i_clk = ~i_clk;
   end

   always @(posedge i_clk)
      if (o_wb_ack === 1'b1 && i_wb_we === 1'b0)
      begin
         if (exp_q.size() == 0)
            cmp(1, 0);
         else
            cmp(exp_q.pop_front(), o_wb_dat);
      end

   always @(posedge i_clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         n_fail++;
         finish_test();
      end
   end

   // --------------------------------------------------------------------
   // Main sequence
   // --------------------------------------------------------------------
   initial
   begin
      {i_nrst, i_wb_cyc, i_wb_stb, i_wb_we, i_wb_adr, i_wb_sel, i_wb_dat} <= '0;
      seed = 32'h04d595f8;
      cfg_m = 32'h0;
      low_m = 2'h0;
      repeat (4) @(posedge i_clk);
      i_nrst <= 1'b1;
      rd(8'h20, 32'h0);
      rd(8'h40, 32'h0);
      chk_route();
      for (int k = 0; k < 4; k++)
      begin
         c = k[1:0];
         wr(8'h20, 4'hf, {c, 2'h3, c, c, c, c, c[1], c[1], 2'h3, c, c, c, c, 8'hff});
         wr(8'h40, 4'hf, {30'h0, c[0], c[0]});
         rd(8'h20, cfg_m);
         chk_route();
      end
      wr(8'h44, 4'hf, 32'hffffffff);
      rd(8'h44, 32'h0);
      rd(8'h20, cfg_m);
      for (int k = 0; k < 24; k++)
      begin
         wr(($random(seed) & 1) ? 8'h20 : 8'h40, 4'($random(seed)), 32'($random(seed)));
         rd(8'h20, cfg_m);
         rd(8'h40, {30'h0, low_m});
         chk_route();
      end
      repeat (2) @(posedge i_clk);
      finish_test();
   end

endmodule
